/* File: rtl/ecss_top.sv */
// Summary of operation
// - Unstructured calls code AAL type 0x01 and subtype 0x02.
// - DS3 unstructured calls code rate 0x07 (44736 kbit/s).
// - E3 unstructured calls code rate 0x12 (34368 kbit/s).
// - Clock recovery: 0x00 null, 0x01 residual timestamp, 0x02 adaptive.
// - Low-layer octet 7 layer-3 protocol coded 01011.
// - Octets 7a/7b coded 0x40 and 0x00 for SNAP identifier.
// - Octets 8.1-8.3 carry the fixed organizational identifier.
// - Protocol id 0x0000 unstructured, 0x0006 basic Nx64.
// - CAS protocol ids: E1 0x0007, SF 0x0008, ESF 0x0009, J2 0x000B.
// - Listening mode only waits; never originates a call.
// - Calling mode attempts calls periodically when no call is up.
// - Kind selects PVC attach, calling procedure, or accepting calls.
// - Selecting calling mode creates the auto-call entry automatically.
// - Call only with remote address set, link up, no call active.
// - Remote address change during a call in calling mode clears it.
// - Retry failed calls per initial period below nonzero limit.
// - At the limit, attempts stop until management intervenes.
// - Restart write clears failure count and restarts calling.
// - No parameter negotiation; unsupported parameters just fail.
// - Collision: accept incoming if source < destination, else clear it.
// - Retry period gets a random offset and progressive backoff.
`timescale 1ns/1ns
`default_nettype none
`include "ecss_regs.svh"
module ecss_top
  import ecss_pkg::*;
#(
  parameter int ADDR_W = 20,              // Width of endpoint address
  parameter int CNT_W  = 16,              // Width of failure counter
  parameter logic [23:0] ORG_ID = 24'h12_3456 // Arbitrary identifier value
) (
  input  wire  logic              CORE_CLK,     // System clock
  input  wire  logic              RST,          // Sync reset, high
  input  wire  logic              PSEL,         // APB select
  input  wire  logic              PENABLE,      // APB enable
  input  wire  logic              PWRITE,       // APB direction
  input  wire  logic [11:0]       PADDR,        // APB address
  input  wire  logic [31:0]       PWDATA,       // APB write data
  output var   logic [31:0]       PRDATA,       // APB read data
  output var   logic              PREADY,       // APB ready
  output var   logic              PSLVERR,      // APB error
  input  wire  logic              LINK_UP,      // ATM link available
  input  wire  logic              CALL_CONNECTED, // Outgoing call connected
  input  wire  logic              CALL_FAILED,  // Outgoing call rejected
  input  wire  logic              CALL_CLEARED, // Established call cleared
  input  wire  logic              INCOMING,     // Valid incoming call
  input  wire  logic [ADDR_W-1:0] IN_SRC_ADDR,  // Incoming source address
  input  wire  logic [ADDR_W-1:0] IN_DST_ADDR,  // Incoming destination addr
  output var   ecss_sig_s         SIG_REQ,      // Signalling pulses
  output var   logic              PVC_ATTACH,   // Attach to provisioned PVC
  output var   logic              LISTEN_READY, // Accepting incoming calls
  output var   logic              CALL_UP       // A call is established
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  ecss_kind_e          kind;
  logic                remote_set;
  ecss_svc_e           svc;
  logic [1:0]          clk_method;
  logic [15:0]         retry_period;
  logic [CNT_W-1:0]    max_failed;
  logic [ADDR_W-1:0]   local_addr;
  logic [ADDR_W-1:0]   remote_addr;
  logic [CNT_W-1:0]    failed_cnt;
  logic                auto_entry;
  logic                restart_pulse;
  logic                remote_change;
  ecss_state_e         state;
  logic [31:0]         wait_cnt;
  logic [31:0]         backoff;
  logic [15:0]         lfsr;
  logic                apb_wr;
  logic                apb_rd;
  logic [31:0]         next_rdata;
  logic [7:0]          rate_code;
  logic [15:0]         pid_code;
  logic                limit_hit;
  logic                may_call;

  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;

  // --------------------------------------------------------------------
  // APB ready: one wait state, one response per access
  // --------------------------------------------------------------------
  // Ready is registered, so each access takes exactly one extra cycle.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
    end
  end

  // Unmapped addresses answer with an error, writes there are dropped
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= PSEL && PENABLE && !PREADY && (PADDR > `ECSS_OFF_PID_IE || PADDR[1:0] != 2'b00);
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Writes land in the cycle where PREADY is raised toward the master
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      kind         <= ECSS_KIND_IDLE;
      remote_set   <= 1'b0;
      svc          <= ECSS_SVC_DS3;
      clk_method   <= 2'b00;
      retry_period <= 16'(`ECSS_RST_RETRY);
      max_failed   <= '0;
      local_addr   <= '0;
      remote_addr  <= '0;
    end else if (apb_wr && !PREADY) begin
      case (PADDR)
        `ECSS_OFF_CTRL: begin
          kind       <= ecss_kind_e'(PWDATA[`ECSS_CTRL_KIND_LSB +: 2]);
          remote_set <= PWDATA[`ECSS_CTRL_REMOTE_OK];
        end
        `ECSS_OFF_SERVICE: begin
          svc        <= ecss_svc_e'(PWDATA[3:0]);
          clk_method <= PWDATA[9:8];
        end
        `ECSS_OFF_RETRY: begin
          retry_period <= PWDATA[15:0];
          max_failed   <= PWDATA[`ECSS_RETRY_LIMIT_LSB +: CNT_W];
        end
        `ECSS_OFF_LOCAL_ADDR:  local_addr  <= PWDATA[ADDR_W-1:0];
        `ECSS_OFF_REMOTE_ADDR: remote_addr <= PWDATA[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  // Restart strobe and remote-address change strobe
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      restart_pulse <= 1'b0;
      remote_change <= 1'b0;
    end else begin
      restart_pulse <= apb_wr && !PREADY && PADDR == `ECSS_OFF_RESTART
                       && PWDATA == `ECSS_RESTART_VALUE;
      remote_change <= apb_wr && !PREADY && PADDR == `ECSS_OFF_REMOTE_ADDR
                       && PWDATA[ADDR_W-1:0] != remote_addr;
    end
  end

  // Auto-call entry exists whenever calling mode is selected
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      auto_entry <= 1'b0;
    end else begin
      auto_entry <= (kind == ECSS_KIND_CALL);
    end
  end

  // --------------------------------------------------------------------
  // Setup element encodings
  // --------------------------------------------------------------------
  // Rate code only meaningful for the unstructured services
  always_comb begin
    rate_code = (svc == ECSS_SVC_E3) ? `ECSS_RATE_E3 : `ECSS_RATE_DS3;
    case (svc)
      ECSS_SVC_BASIC:  pid_code = `ECSS_PID_BASIC;
      ECSS_SVC_E1CAS:  pid_code = `ECSS_PID_E1_CAS;
      ECSS_SVC_SFCAS:  pid_code = `ECSS_PID_DS1SF_CAS;
      ECSS_SVC_ESFCAS: pid_code = `ECSS_PID_DS1ESF_CAS;
      ECSS_SVC_J2CAS:  pid_code = `ECSS_PID_J2_CAS;
      default:         pid_code = `ECSS_PID_UNSTRUCT;
    endcase
  end

  // --------------------------------------------------------------------
  // Call sequencer
  // --------------------------------------------------------------------
  assign limit_hit = (max_failed != '0) && (failed_cnt >= max_failed);
  assign may_call  = auto_entry && remote_set && LINK_UP && !limit_hit;

  // Random jitter avoids both ends retrying in lock step
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      lfsr <= 16'hACE1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // Failed attempts counted and held until restart
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      failed_cnt <= '0;
    end else if (restart_pulse) begin
      failed_cnt <= '0;
    end else if (state == ECSS_ST_CALLING && CALL_FAILED && !(&failed_cnt)) begin
      failed_cnt <= failed_cnt + 1'b1;
    end
  end

  // Main connection state machine; no parameter renegotiation is tried
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state    <= ECSS_ST_IDLE;
      wait_cnt <= '0;
      backoff  <= '0;
      SIG_REQ  <= '0;
    end else begin
      SIG_REQ <= '0;
      case (state)
        ECSS_ST_IDLE: begin
          if (kind == ECSS_KIND_PVC) begin
            state <= ECSS_ST_PVC;
          end else if (kind == ECSS_KIND_LISTEN) begin
            state <= ECSS_ST_LISTEN;
          end else if (may_call) begin
            state          <= ECSS_ST_CALLING;
            SIG_REQ.setup  <= 1'b1;
          end
        end
        ECSS_ST_CALLING: begin
          // Leaving calling mode abandons the attempt in flight
          if (kind != ECSS_KIND_CALL) begin
            SIG_REQ.release_out <= 1'b1;
            state               <= ECSS_ST_IDLE;
          end else if (INCOMING) begin
            if (IN_SRC_ADDR < IN_DST_ADDR) begin
              SIG_REQ.accept_in   <= 1'b1;
              SIG_REQ.release_out <= 1'b1;
              state               <= ECSS_ST_ACTIVE;
            end else begin
              SIG_REQ.release_in <= 1'b1;
            end
          end else if (CALL_CONNECTED) begin
            state   <= ECSS_ST_ACTIVE;
            backoff <= '0;
          end else if (CALL_FAILED) begin
            state    <= ECSS_ST_WAIT;
            wait_cnt <= 32'({retry_period, 4'h0}) * `ECSS_RETRY_UNIT_CYC / 16
                        + backoff + 32'(lfsr[7:0]);
            backoff  <= backoff + 32'(`ECSS_RETRY_UNIT_CYC);
          end
        end
        ECSS_ST_ACTIVE: begin
          if (remote_change && kind == ECSS_KIND_CALL) begin
            SIG_REQ.release_out <= 1'b1;
            state               <= ECSS_ST_IDLE;
          end else if (kind == ECSS_KIND_PVC || kind == ECSS_KIND_IDLE) begin
            SIG_REQ.release_out <= 1'b1;
            state               <= ECSS_ST_IDLE;
          end else if (CALL_CLEARED) begin
            state <= (kind == ECSS_KIND_LISTEN) ? ECSS_ST_LISTEN : ECSS_ST_IDLE;
          end
        end
        ECSS_ST_WAIT: begin
          if (kind != ECSS_KIND_CALL) begin
            state <= ECSS_ST_IDLE;
          end else if (limit_hit) begin
            state <= ECSS_ST_HALTED;
          end else if (wait_cnt == 32'd0) begin
            state <= ECSS_ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 32'd1;
          end
        end
        ECSS_ST_HALTED: begin
          if (restart_pulse || kind != ECSS_KIND_CALL) begin
            state   <= ECSS_ST_IDLE;
            backoff <= '0;
          end
        end
        ECSS_ST_PVC: begin
          if (kind != ECSS_KIND_PVC) state <= ECSS_ST_IDLE;
        end
        ECSS_ST_LISTEN: begin
          if (kind != ECSS_KIND_LISTEN) begin
            state <= ECSS_ST_IDLE;
          end else if (INCOMING) begin
            SIG_REQ.accept_in <= 1'b1;
            state             <= ECSS_ST_ACTIVE;
          end
        end
        default: state <= ECSS_ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PVC_ATTACH   <= 1'b0;
      LISTEN_READY <= 1'b0;
      CALL_UP      <= 1'b0;
    end else begin
      PVC_ATTACH   <= (state == ECSS_ST_PVC);
      LISTEN_READY <= (state == ECSS_ST_LISTEN);
      CALL_UP      <= (state == ECSS_ST_ACTIVE);
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (PADDR)
      `ECSS_OFF_CTRL:        next_rdata = {29'h0, remote_set, kind};
      `ECSS_OFF_SERVICE:     next_rdata = {22'h0, clk_method, 4'h0, svc};
      `ECSS_OFF_RETRY:       next_rdata = {CNT_W'(max_failed), retry_period};
      `ECSS_OFF_LOCAL_ADDR:  next_rdata = 32'(local_addr);
      `ECSS_OFF_REMOTE_ADDR: next_rdata = 32'(remote_addr);
      `ECSS_OFF_STATUS:      next_rdata = {CNT_W'(failed_cnt), 8'h0, 3'h0, auto_entry, limit_hit, state};
      `ECSS_OFF_AAL_IE:      next_rdata = {`ECSS_AAL_TYPE1, `ECSS_SUBTYPE_CIRCUIT,
                                           rate_code, 6'h0, clk_method};
      `ECSS_OFF_BLLI_IE:     next_rdata = {3'h0, `ECSS_L3_MULTIPROTO,
                                           `ECSS_OCT7A_SNAP, `ECSS_OCT7B_SNAP,
                                           ORG_ID[23:16]};
      // Octet 8.1 rides in the low byte above; octets 8.2-8.3 and the
      // two protocol id octets fill this word, so all five are readable
      // without widening the register map.
      `ECSS_OFF_PID_IE:      next_rdata = {ORG_ID[15:0], pid_code};
      default:               next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered alongside PREADY
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (apb_rd && !PREADY) begin
      PRDATA <= next_rdata;
    end
  end

endmodule // ecss_top
`default_nettype wire

/* File: rtl/ecss_regs.svh */
`ifndef ECSS_REGS_SVH
`define ECSS_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define ECSS_OFF_CTRL        12'h000
`define ECSS_OFF_SERVICE     12'h004
`define ECSS_OFF_RETRY       12'h008
`define ECSS_OFF_LOCAL_ADDR  12'h00C
`define ECSS_OFF_REMOTE_ADDR 12'h010
`define ECSS_OFF_RESTART     12'h014
`define ECSS_OFF_STATUS      12'h018
`define ECSS_OFF_AAL_IE      12'h01C
`define ECSS_OFF_BLLI_IE     12'h020
`define ECSS_OFF_PID_IE      12'h024
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ECSS_CTRL_KIND_LSB   0
`define ECSS_CTRL_REMOTE_OK  2
`define ECSS_RETRY_LIMIT_LSB 16
`define ECSS_RESTART_VALUE   32'h0000_0001
// ----------------------------------------------------------------------
// Information element encodings
// ----------------------------------------------------------------------
`define ECSS_AAL_TYPE1       8'h01
`define ECSS_SUBTYPE_CIRCUIT 8'h02
`define ECSS_RATE_DS3        8'h07
`define ECSS_RATE_E3         8'h12
`define ECSS_CLK_NULL        8'h00
`define ECSS_CLK_RESIDUAL    8'h01
`define ECSS_CLK_ADAPTIVE    8'h02
`define ECSS_L3_MULTIPROTO   5'h0B
`define ECSS_OCT7A_SNAP      8'h40
`define ECSS_OCT7B_SNAP      8'h00
`define ECSS_PID_UNSTRUCT    16'h0000
`define ECSS_PID_BASIC       16'h0006
`define ECSS_PID_E1_CAS      16'h0007
`define ECSS_PID_DS1SF_CAS   16'h0008
`define ECSS_PID_DS1ESF_CAS  16'h0009
`define ECSS_PID_J2_CAS      16'h000B
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define ECSS_RST_RETRY       32'h0000_0064
`define ECSS_RETRY_UNIT_US   10
`define ECSS_CLK_MHZ         100
`define ECSS_RETRY_UNIT_CYC  (`ECSS_RETRY_UNIT_US * `ECSS_CLK_MHZ)
`endif

/* File: rtl/ecss_pkg.sv */
package ecss_pkg;
  // Connection kind
  typedef enum logic [1:0] {
    ECSS_KIND_PVC    = 2'b00,
    ECSS_KIND_CALL   = 2'b01,
    ECSS_KIND_LISTEN = 2'b10,
    ECSS_KIND_IDLE   = 2'b11
  } ecss_kind_e;
  // Service selector for the setup elements
  typedef enum logic [3:0] {
    ECSS_SVC_DS3    = 4'h0,
    ECSS_SVC_E3     = 4'h1,
    ECSS_SVC_BASIC  = 4'h2,
    ECSS_SVC_E1CAS  = 4'h3,
    ECSS_SVC_SFCAS  = 4'h4,
    ECSS_SVC_ESFCAS = 4'h5,
    ECSS_SVC_J2CAS  = 4'h6
  } ecss_svc_e;
  // Call sequencer states
  typedef enum logic [2:0] {
    ECSS_ST_IDLE    = 3'b000,
    ECSS_ST_CALLING = 3'b001,
    ECSS_ST_ACTIVE  = 3'b010,
    ECSS_ST_WAIT    = 3'b011,
    ECSS_ST_HALTED  = 3'b100,
    ECSS_ST_PVC     = 3'b101,
    ECSS_ST_LISTEN  = 3'b110
  } ecss_state_e;
  // Signalling requests toward the network
  typedef struct packed {
    logic setup;
    logic release_out;
    logic accept_in;
    logic release_in;
  } ecss_sig_s;
endpackage

/* File: tb/ecss_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module ecss_assertions
  import ecss_pkg::*;
#(
  parameter int ADDR_W = 20 // Address width
) (
  input wire logic              CORE_CLK,       // Clock
  input wire logic              RST,            // Sync reset
  input wire logic              PSEL,           // APB select
  input wire logic              PENABLE,        // APB enable
  input wire logic              PREADY,         // APB ready
  input wire logic              LINK_UP,        // Link available
  input wire logic              CALL_CONNECTED, // Connected pulse
  input wire logic              CALL_FAILED,    // Rejected pulse
  input wire logic              INCOMING,       // Incoming pulse
  input wire logic [ADDR_W-1:0] IN_SRC_ADDR,    // Incoming source
  input wire logic [ADDR_W-1:0] IN_DST_ADDR,    // Incoming destination
  input wire ecss_sig_s         SIG_REQ,        // Signalling pulses
  input wire logic              PVC_ATTACH,     // PVC level
  input wire logic              LISTEN_READY,   // Listening level
  input wire logic              CALL_UP         // Call level
);
  // ----------------------------------------
  // Outgoing call tracking
  // ----------------------------------------
  logic pend;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Set by our setup, cleared by any network answer
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pend <= 1'b0;
    end else if (SIG_REQ.setup) begin
      pend <= 1'b1;
    end else if (CALL_CONNECTED || CALL_FAILED || INCOMING) begin
      pend <= 1'b0;
    end
  end
  property p_ready; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_listen; LISTEN_READY |-> !SIG_REQ.setup; endproperty
  a_listen: assert property (p_listen) else $error("listener called");
  property p_busy; CALL_UP |-> !SIG_REQ.setup; endproperty
  a_busy: assert property (p_busy) else $error("setup during call");
  property p_link; !LINK_UP ##1 !LINK_UP |-> !SIG_REQ.setup; endproperty
  a_link: assert property (p_link) else $error("setup with link down");
  property p_gap; CALL_FAILED |=> !SIG_REQ.setup [*8]; endproperty
  a_gap: assert property (p_gap) else $error("retry too soon");
  property p_pvc; PVC_ATTACH |-> !SIG_REQ.setup && !LISTEN_READY; endproperty
  a_pvc: assert property (p_pvc) else $error("pvc mixed");
  property p_up;
    $rose(CALL_UP) |-> $past(CALL_CONNECTED, 2) || $past(INCOMING) || $past(INCOMING, 2);
  endproperty
  a_up: assert property (p_up) else $error("call up without cause");
  property p_acc;
    INCOMING && pend && IN_SRC_ADDR < IN_DST_ADDR |=> SIG_REQ.accept_in && SIG_REQ.release_out;
  endproperty
  a_acc: assert property (p_acc) else $error("collision not accepted");
  property p_rej;
    INCOMING && pend && IN_SRC_ADDR >= IN_DST_ADDR |=> SIG_REQ.release_in && !SIG_REQ.accept_in;
  endproperty
  a_rej: assert property (p_rej) else $error("collision not refused");
endmodule // ecss_assertions
bind ecss_top ecss_assertions #(.ADDR_W(ADDR_W)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .LINK_UP(LINK_UP), .CALL_CONNECTED(CALL_CONNECTED),
  .CALL_FAILED(CALL_FAILED), .INCOMING(INCOMING), .IN_SRC_ADDR(IN_SRC_ADDR), .IN_DST_ADDR(IN_DST_ADDR),
  .SIG_REQ(SIG_REQ), .PVC_ATTACH(PVC_ATTACH), .LISTEN_READY(LISTEN_READY), .CALL_UP(CALL_UP));
`default_nettype wire

/* File: tb/ecss_net_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ecss_net_model
  import ecss_pkg::*;
(
  input  wire logic       clk,    // Clock
  input  wire logic       rst,    // Sync reset
  input  wire ecss_sig_s  req,    // Endpoint requests
  input  wire logic [1:0] mode,   // 0 connect, 1 reject, 2 silent
  input  wire logic       inc_go, // Offer an incoming call
  output var logic        conn,   // Connected pulse
  output var logic        fail,   // Rejected pulse
  output var logic        inc     // Incoming pulse
);
  int   cnt;
  logic rej;
  // Answer quickly on connect, slowly on reject; silent never answers
  always_ff @(posedge clk) begin
    conn <= 1'b0;
    fail <= 1'b0;
    inc  <= inc_go && !rst;
    if (rst || req.release_out) begin
      cnt <= 0;
    end else if (req.setup && mode != 2'd2) begin
      cnt <= (mode == 2'd0) ? 2 : 20;
      rej <= mode[0];
    end else if (cnt == 1) begin
      conn <= !rej;
      fail <= rej;
      cnt  <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // ecss_net_model
`default_nettype wire

/* File: tb/ecss_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ecss_regs.svh"
module ecss_top_bench
  import ecss_pkg::*;
;
  localparam logic [15:0] PIDS [7] = '{16'h0000, 16'h0000, 16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000B};
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        link_up = 1'b0, inc_go = 1'b0, pready, pslverr, err;
  logic        conn, fail, inc, pvc, lsn, up;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [19:0] src = 20'h0_0000, dst = 20'h0_0000;
  logic [1:0]  mode = 2'd2;
  ecss_sig_s   req;
  int          failures = 0, checks_done = 0, ns = 0, nro = 0, nac = 0, nri = 0;
  always #5 clk = ~clk;
  // Count every signalling pulse so tasks judge by difference
  always @(posedge clk) begin
    ns  += int'(req.setup === 1'b1);
    nro += int'(req.release_out === 1'b1);
    nac += int'(req.accept_in === 1'b1);
    nri += int'(req.release_in === 1'b1);
  end
  ecss_top #(.ADDR_W(20)) u_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK_UP(link_up),
    .CALL_CONNECTED(conn), .CALL_FAILED(fail), .CALL_CLEARED(1'b0), .INCOMING(inc), .IN_SRC_ADDR(src),
    .IN_DST_ADDR(dst), .SIG_REQ(req), .PVC_ATTACH(pvc), .LISTEN_READY(lsn), .CALL_UP(up));
  ecss_net_model u_net (.clk(clk), .rst(rst), .req(req), .mode(mode), .inc_go(inc_go), .conn(conn),
    .fail(fail), .inc(inc));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // Request held until the edge that samples ready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Ready looked at mid-cycle; release only after the edge that samples it
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    check(n < 50, "no ready");
  endtask
  task automatic wait_setup(input int lim);
    int n0;
    n0 = ns;
    repeat (lim) if (ns == n0) @(posedge clk);
  endtask
  task automatic offer(input logic [19:0] s, input logic [19:0] d);
    src <= s;
    dst <= d;
    inc_go <= 1'b1;
    @(posedge clk);
    inc_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_codes;
    apb(0, `ECSS_OFF_RETRY, 0);
    check(rd === `ECSS_RST_RETRY, "retry reset");
    apb(0, 12'h028, 0);
    check(err === 1'b1 && rd === 32'h0000_0000, "unmapped");
    apb(0, `ECSS_OFF_BLLI_IE, 0);
    check(rd[28:24] === 5'h0B, "layer3");
    check(rd[23:8] === 16'h4000, "snap");
    for (int s = 0; s < 7; s++) begin
      apb(1, `ECSS_OFF_SERVICE, (32'(s % 3) << 8) | 32'(s));
      apb(0, `ECSS_OFF_AAL_IE, 0);
      check(rd[31:16] === 16'h0102, "aal type");
      check(rd[7:0] === 8'(s % 3), "clock method");
      if (s == 0) check(rd[15:8] === 8'h07, "ds3 rate");
      if (s == 1) check(rd[15:8] === 8'h12, "e3 rate");
      apb(0, `ECSS_OFF_PID_IE, 0);
      check(rd[15:0] === PIDS[s], "protocol id");
    end
  endtask
  task automatic t_modes;
    int n0;
    n0 = ns;
    link_up <= 1'b1;
    apb(1, `ECSS_OFF_REMOTE_ADDR, 32'h0000_0111);
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0006);
    repeat (300) @(posedge clk);
    check(lsn === 1'b1 && ns == n0, "listen");
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0004);
    repeat (5) @(posedge clk);
    check(pvc === 1'b1 && lsn === 1'b0, "pvc");
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0001);
    repeat (300) @(posedge clk);
    check(ns == n0, "no remote");
    apb(0, `ECSS_OFF_STATUS, 0);
    check(rd[4] === 1'b1, "auto entry");
  endtask
  task automatic t_connect;
    int n0;
    n0 = nro;
    mode <= 2'd0;
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0005);
    wait_setup(500);
    repeat (10) @(posedge clk);
    check(up === 1'b1, "call up");
    apb(1, `ECSS_OFF_REMOTE_ADDR, 32'h0000_0222);
    repeat (3) @(posedge clk);
    check(nro > n0, "remote change");
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0003);
  endtask
  task automatic t_collide;
    int a0;
    int r0;
    a0 = nac;
    r0 = nri;
    mode <= 2'd2;
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0005);
    wait_setup(500);
    offer(20'h0_0001, 20'h0_0005);
    check(nac == a0 + 1, "accept");
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0003);
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0005);
    wait_setup(500);
    offer(20'h0_0009, 20'h0_0002);
    check(nri == r0 + 1 && nac == a0 + 1, "refuse");
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0003);
  endtask
  task automatic t_retry;
    int n0;
    mode <= 2'd1;
    apb(1, `ECSS_OFF_RETRY, 32'h0002_0001);
    n0 = ns;
    apb(1, `ECSS_OFF_CTRL, 32'h0000_0005);
    repeat (9000) @(posedge clk);
    check(ns == n0 + 2, "attempts");
    apb(0, `ECSS_OFF_STATUS, 0);
    check(rd[31:16] === 16'h0002 && rd[3] === 1'b1, "count");
    apb(1, `ECSS_OFF_RESTART, `ECSS_RESTART_VALUE);
    apb(0, `ECSS_OFF_STATUS, 0);
    check(rd[31:16] === 16'h0000, "cleared");
    wait_setup(200);
    check(ns == n0 + 3, "restarted");
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_codes();
    t_modes();
    t_connect();
    t_collide();
    t_retry();
    end_sim();
  end
  // Watchdog, far beyond the longest retry wait
  initial begin
    #500_000;
    failures++;
    end_sim();
  end
endmodule // ecss_top_bench
`default_nettype wire
